// [dv/four_channel_pulse_totalizer_bench.sv]
// Self-checking bench for the four channel pulse totalizer
`include "pct_defs.vh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
	n_errors++; $display("ERROR %s exp %h got %h", nm, exp, got); end end
module four_channel_pulse_totalizer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEC = 200;
	logic CLK = 1'h0;
	logic RST_B = 1'h0;
	logic [3:0] PULSE_IN = 4'h0;
	logic [3:0] ADDR_JUMPER = 4'h9;
	logic [3:0] S_AXI_WSTRB = 4'hf;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, SER_TX, SER_TX_OE, ACTIVITY_LED;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire logic SER_RX;
	// Released line is biased to idle high
	wire logic line_up = SER_TX_OE ? SER_TX : 1'h1;
	int n_errors = 0, n_compared = 0, cyc = 0, seed = 32'h92cc;
	logic [19:0] tot [4];
	logic [31:0] wraps [4];
	logic [15:0] mult [4];
	pct_top #(.SEC_CYCLES(SEC), .HB_CYCLES(20)) u_dut (
		.CLK, .RST_B, .PULSE_IN, .ADDR_JUMPER, .SER_RX, .SER_TX, .SER_TX_OE,
		.ACTIVITY_LED, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
		.S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
		.S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
		.S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY
	);
	pct_host u_host (.clk(CLK), .line_in(line_up), .line_out(SER_RX));
	always #5 CLK = ~CLK;
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] r);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		while (!(aw && w)) begin
			@(posedge CLK);
			if (!aw && S_AXI_AWREADY) begin
				aw = 1'h1;
				S_AXI_AWVALID <= 1'h0;
			end
			if (!w && S_AXI_WREADY) begin
				w = 1'h1;
				S_AXI_WVALID <= 1'h0;
			end
		end
		do @(posedge CLK); while (!S_AXI_BVALID);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] r);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do @(posedge CLK); while (!S_AXI_ARREADY);
		S_AXI_ARVALID <= 1'h0;
		do @(posedge CLK); while (!S_AXI_RVALID);
		v = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'h0;
	endtask
	// High three cycles, ten cycles per pulse
	task automatic pulse(input logic [3:0] m);
		@(posedge CLK);
		PULSE_IN <= m;
		repeat (3) @(posedge CLK);
		PULSE_IN <= 4'h0;
		repeat (6) @(posedge CLK);
	endtask
	function automatic logic [20:0] step(input logic [19:0] t,
		input logic [15:0] m);
		logic [20:0] s;
		s = {1'h0, t} + {5'h00, m};
		return (s >= `PCT_WRAP_LIMIT) ? {1'h1, 20'(s - `PCT_WRAP_LIMIT)} : s;
	endfunction
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] b;
		logic ok, w;
		logic [3:0] m;
		repeat (4) @(posedge CLK);
		RST_B <= 1'h1;
		repeat (6) @(posedge CLK);
		rd(`PCT_OFF_STATUS, d, r);
		`CHK("status", 5'h19, d[4:0]);
		rd(8'h40, d, r);
		`CHK("bad_rd", 34'h2_0000_0000, {r, d});
		wr(8'h44, 32'h0000_0001, r);
		`CHK("bad_wr", 2'h2, r);
		wr(`PCT_OFF_MODE, 32'h0000_00ff, r);
		wr(`PCT_OFF_CLEAR, 32'h0000_000f, r);
		for (int i = 0; i < 4; i++) begin
			rd(`PCT_OFF_MULT + 8'(4 * i), d, r);
			`CHK("mult_rst", 32'h0000_0001, d);
			mult[i] = (i == 3) ? 16'hffff : 16'($random(seed));
			tot[i] = 20'h0_0000;
			wraps[i] = 32'h0000_0000;
			wr(`PCT_OFF_MULT + 8'(4 * i), {16'h0000, mult[i]}, r);
		end
		repeat (40) begin
			m = 4'($random(seed));
			pulse(m);
			for (int i = 0; i < 4; i++)
				if (m[i]) begin
					{w, tot[i]} = step(tot[i], mult[i]);
					wraps[i] = wraps[i] + {31'h0000_0000, w};
				end
		end
		for (int i = 0; i < 4; i++) begin
			rd(`PCT_OFF_TOTAL + 8'(4 * i), d, r);
			`CHK("total", {12'h000, tot[i]}, d);
			rd(`PCT_OFF_VIRT + 8'(4 * i), d, r);
			`CHK("wraps", wraps[i], d);
		end
		wr(`PCT_OFF_MODE, 32'h0000_00e4, r);
		rd(`PCT_OFF_MODE, d, r);
		`CHK("mode", 32'h0000_00e4, d);
		wr(`PCT_OFF_CLEAR, 32'h0000_0001, r);
		fork
			repeat (60) pulse(4'h3);
			begin
				repeat (450) @(posedge CLK);
				rd(`PCT_OFF_VIRT, d, r);
			end
		join
		`CHK("rate", 32'(mult[0]) * (SEC / 10), d);
		S_AXI_WSTRB <= 4'h2;
		wr(`PCT_OFF_MULT, 32'h0000_a5a5, r);
		S_AXI_WSTRB <= 4'hf;
		rd(`PCT_OFF_MULT, d, r);
		`CHK("strobe", {16'h0000, 8'ha5, mult[0][7:0]}, d);
		u_host.poll(4'h9, b, ok);
		`CHK("reply", 9'h1a9, {ok, b});
		u_host.poll(4'h5, b, ok);
		`CHK("no_reply", 1'h0, ok);
		// All sixty input two pulses fall in the first minute
		rd(`PCT_OFF_VIRT + 8'h04, d, r);
		`CHK("per_min", 32'(mult[1]) * 60, d);
		tally_and_finish();
	end
endmodule

// [dv/pct_host.sv]
// Main controller model on the serial expansion link
module pct_host #(
	parameter BIT_CYC = 651
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial line_out = 1'h1;
	// Start, eight data bits LSB first, stop
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line_out <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
	endtask
	// Samples mid bit; gives up after twelve bit times of silence
	task automatic recv_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'h0;
		b = 8'h00;
		while (line_in && n < 12 * BIT_CYC) begin
			@(posedge clk);
			n++;
		end
		if (!line_in) begin
			repeat (BIT_CYC / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk);
				b[i] = line_in;
			end
			repeat (BIT_CYC) @(posedge clk);
			ok = line_in;
		end
	endtask
	// Only addresses one to fifteen are polled
	task automatic poll(input logic [3:0] a, output logic [7:0] r,
		output logic ok);
		fork
			send_byte({4'h0, a});
			recv_byte(r, ok);
		join
	endtask
endmodule

// [dv/pct_top_properties.sv]
// Port checker for the pulse totalizer top, bound below
`include "pct_defs.vh"
module pct_top_chk #(
	parameter HB_CYCLES = 20
) (
	input wire CLK,
	input wire RST_B,
	input wire SER_TX,
	input wire SER_TX_OE,
	input wire ACTIVITY_LED,
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire S_AXI_BVALID,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire S_AXI_RVALID
);
	reg [31:0] hb_q;
	reg led_q;
	reg seen_q;
	reg tot_q;
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			hb_q <= 32'h0000_0000;
			led_q <= 1'h0;
			seen_q <= 1'h0;
			tot_q <= 1'h0;
		end else begin
			led_q <= ACTIVITY_LED;
			hb_q <= (ACTIVITY_LED != led_q) ? 32'h0000_0000 : hb_q + 32'h0000_0001;
			if (ACTIVITY_LED != led_q)
				seen_q <= 1'h1;
			if (S_AXI_ARVALID && S_AXI_ARREADY)
				tot_q <= (S_AXI_ARADDR[7:4] == 4'h2);
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_wr_both;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence s_b_late;
		!S_AXI_BVALID ##1 S_AXI_BVALID;
	endsequence
	property p_wr_lat;
		s_wr_both |=> s_b_late;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_wr_busy;
		s_wr_both |=> !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write not blocked");
	property p_rd_lat;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_tot_range;
		S_AXI_RVALID && tot_q |-> S_AXI_RDATA < {11'h000, `PCT_WRAP_LIMIT};
	endproperty
	a_tot_range: assert property (p_tot_range) else $error("total too big");
	property p_tx_idle;
		!SER_TX_OE |-> SER_TX;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx not idle high");
	property p_tx_start;
		$rose(SER_TX_OE) |-> !SER_TX;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start bit");
	property p_led_period;
		seen_q && (ACTIVITY_LED != led_q) |-> hb_q == HB_CYCLES - 1;
	endproperty
	a_led_period: assert property (p_led_period) else $error("led period");
	property p_led_alive;
		seen_q |-> hb_q < HB_CYCLES;
	endproperty
	a_led_alive: assert property (p_led_alive) else $error("led stuck");
endmodule

bind pct_top pct_top_chk #(.HB_CYCLES(HB_CYCLES)) u_chk (
	.CLK, .RST_B, .SER_TX, .SER_TX_OE, .ACTIVITY_LED, .S_AXI_AWVALID,
	.S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
	.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
	.S_AXI_RVALID
);

// [rtl/pct_chan.v]
// One total channel with its paired virtual channel
`include "pct_defs.vh"
module pct_chan (
	input wire clk,
	input wire rst_b,
	input wire pulse,
	input wire clr,
	input wire [15:0] mult,
	input wire [1:0] mode,
	input wire sec_tick,
	input wire min_tick,
	input wire hour_tick,
	output reg [19:0] total_reg,
	output reg [31:0] virt_reg
);
	reg [31:0] acc_reg;
	wire [20:0] sum = {1'b0, total_reg} + {5'h0, mult};
	wire wrap = pulse & (sum >= `PCT_WRAP_LIMIT);
	wire [20:0] sum_wrapped = sum - `PCT_WRAP_LIMIT;
	wire [32:0] acc_add = {1'b0, acc_reg} + {17'h0, mult};
	// Saturate rather than roll over on absurd multipliers
	wire [31:0] acc_sat = acc_add[32] ? 32'hffff_ffff : acc_add[31:0];
	reg win;

	always @* begin
		case (mode)
		`PCT_MODE_SEC: win = sec_tick;
		`PCT_MODE_MIN: win = min_tick;
		`PCT_MODE_HOUR: win = hour_tick;
		default: win = 1'b0;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			total_reg <= 20'h0_0000;
			virt_reg <= 32'h0000_0000;
			acc_reg <= 32'h0000_0000;
		end else if (clr) begin
			total_reg <= 20'h0_0000;
			virt_reg <= 32'h0000_0000;
			acc_reg <= 32'h0000_0000;
		end else begin
			if (pulse) begin
				// Multiplier below the limit, so one wrap at most
				total_reg <= wrap ? sum_wrapped[19:0] : sum[19:0];
			end
			if (mode == `PCT_MODE_WRAP) begin
				acc_reg <= 32'h0000_0000;
				if (wrap)
					virt_reg <= virt_reg + 32'h0000_0001;
			end else if (win) begin
				// Pulse on the closing edge still belongs to this window
				virt_reg <= pulse ? acc_sat : acc_reg;
				acc_reg <= 32'h0000_0000;
			end else if (pulse) begin
				acc_reg <= acc_sat;
			end
		end
	end
endmodule

// [rtl/pct_defs.vh]
// Shared constants of the four channel pulse totalizer
// Function
// - Totals count to one million, then wrap
// - Count every pulse up to ten kilohertz
// - Virtual channel modes: second, minute, hour, wraps
// - Wrap mode adds one per total wrap
// - Inputs one to four feed channels pairwise
// - Each pulse adds the channel multiplier
// - Module address one to fifteen, unique
// - Address read from four binary jumpers
// - Serial link runs at 153.6 kilobits per second
// - Activity indicator toggles at a steady rate
`ifndef PCT_DEFS_VH
`define PCT_DEFS_VH

`define PCT_CLK_HZ 100_000_000
`define PCT_WIN_S 1
`define PCT_HB_MS 500
`define PCT_MS_PER_S 1000
`define PCT_BIT_RATE 153_600
`define PCT_SEC_PER_MIN 6'h3b
`define PCT_MIN_PER_HOUR 6'h3b

`define PCT_WRAP_LIMIT 21'h0f_4240
`define PCT_MULT_RST 16'h0001

`define PCT_MODE_SEC 2'h0
`define PCT_MODE_MIN 2'h1
`define PCT_MODE_HOUR 2'h2
`define PCT_MODE_WRAP 2'h3

`define PCT_OFF_STATUS 8'h00
`define PCT_OFF_MODE 8'h04
`define PCT_OFF_CLEAR 8'h08
`define PCT_OFF_MULT 8'h10
`define PCT_OFF_TOTAL 8'h20
`define PCT_OFF_VIRT 8'h30
`define PCT_GRP_MASK 8'hf0

`define PCT_RESP_OKAY 2'h0
`define PCT_RESP_SLVERR 2'h2

`define PCT_ADDR_ACK 4'ha

`define PCT_JMP_WAIT 2'h3
`define PCT_RX_LAST 3'h7
`define PCT_TX_LAST 4'h9
`endif

// [rtl/pct_ser.v]
// Serial link end: answers a poll of this module's address
`include "pct_defs.vh"
module pct_ser #(
	parameter BIT_CYC = 651
) (
	input wire clk,
	input wire rst_b,
	input wire rx,
	input wire [3:0] my_addr,
	input wire addr_ok,
	output reg tx_reg,
	output reg tx_oe_reg,
	output reg hit_reg
);
	localparam R_IDLE = 2'h0;
	localparam R_START = 2'h1;
	localparam R_DATA = 2'h2;
	localparam R_STOP = 2'h3;
	localparam T_IDLE = 1'b0;
	localparam T_SEND = 1'b1;
	localparam [31:0] BIT_FULL = BIT_CYC;
	localparam [31:0] HALF_FULL = BIT_CYC / 2;
	localparam [15:0] BIT_W = BIT_FULL[15:0];
	localparam [15:0] HALF_W = HALF_FULL[15:0];

	reg [1:0] rs_reg;
	reg [15:0] rcnt_reg;
	reg [2:0] rbit_reg;
	reg [7:0] rsh_reg;
	reg rx_d_reg;
	reg ts_reg;
	reg [15:0] tcnt_reg;
	reg [3:0] tbit_reg;
	reg [9:0] tsh_reg;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rs_reg <= R_IDLE;
			rcnt_reg <= 16'h0000;
			rbit_reg <= 3'h0;
			rsh_reg <= 8'h00;
			rx_d_reg <= 1'b1;
			hit_reg <= 1'b0;
		end else begin
			rx_d_reg <= rx;
			hit_reg <= 1'b0;
			case (rs_reg)
			R_IDLE: begin
				rcnt_reg <= 16'h0000;
				if (rx_d_reg & ~rx)
					rs_reg <= R_START;
			end
			R_START: begin
				rcnt_reg <= rcnt_reg + 16'h0001;
				if (rcnt_reg == HALF_W) begin
					rcnt_reg <= 16'h0000;
					rbit_reg <= 3'h0;
					rs_reg <= rx ? R_IDLE : R_DATA;
				end
			end
			R_DATA: begin
				rcnt_reg <= rcnt_reg + 16'h0001;
				if (rcnt_reg == BIT_W - 16'h0001) begin
					rcnt_reg <= 16'h0000;
					rsh_reg <= {rx, rsh_reg[7:1]};
					rbit_reg <= rbit_reg + 3'h1;
					if (rbit_reg == `PCT_RX_LAST)
						rs_reg <= R_STOP;
				end
			end
			default: begin
				rcnt_reg <= rcnt_reg + 16'h0001;
				if (rcnt_reg == BIT_W - 16'h0001) begin
					rs_reg <= R_IDLE;
					// Address zero is never answered
					hit_reg <= rx & addr_ok & (rsh_reg == {4'h0, my_addr});
				end
			end
			endcase
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ts_reg <= T_IDLE;
			tcnt_reg <= 16'h0000;
			tbit_reg <= 4'h0;
			tsh_reg <= 10'h3ff;
			tx_reg <= 1'b1;
			tx_oe_reg <= 1'b0;
		end else begin
			case (ts_reg)
			T_IDLE: begin
				tx_reg <= 1'b1;
				tx_oe_reg <= 1'b0;
				if (hit_reg) begin
					tsh_reg <= {1'b1, `PCT_ADDR_ACK, my_addr, 1'b0};
					tcnt_reg <= 16'h0000;
					tbit_reg <= 4'h0;
					ts_reg <= T_SEND;
				end
			end
			default: begin
				tx_oe_reg <= 1'b1;
				tx_reg <= tsh_reg[0];
				tcnt_reg <= tcnt_reg + 16'h0001;
				if (tcnt_reg == BIT_W - 16'h0001) begin
					tcnt_reg <= 16'h0000;
					tsh_reg <= {1'b1, tsh_reg[9:1]};
					tbit_reg <= tbit_reg + 4'h1;
					if (tbit_reg == `PCT_TX_LAST)
						ts_reg <= T_IDLE;
				end
			end
			endcase
		end
	end
endmodule

// [rtl/pct_top.v]
// Four channel pulse totalizer with AXI4-Lite registers and serial link
`include "pct_defs.vh"
module pct_top #(
	parameter SEC_CYCLES = `PCT_WIN_S * `PCT_CLK_HZ,
	parameter HB_CYCLES = `PCT_CLK_HZ / `PCT_MS_PER_S * `PCT_HB_MS
) (
	input wire CLK,
	input wire RST_B,
	input wire [3:0] PULSE_IN,
	input wire [3:0] ADDR_JUMPER,
	input wire SER_RX,
	output reg SER_TX,
	output reg SER_TX_OE,
	output reg ACTIVITY_LED,
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY
);
	localparam BIT_CYC = `PCT_CLK_HZ / `PCT_BIT_RATE;
	localparam [31:0] SEC_LAST = SEC_CYCLES - 1;
	localparam [31:0] HB_LAST = HB_CYCLES - 1;

	// Pin synchronisers; first stage feeds only the second
	reg [3:0] pin_s1_reg;
	reg [3:0] pin_s2_reg;
	reg [3:0] pin_d_reg;
	reg [3:0] jmp_s1_reg;
	reg [3:0] jmp_s2_reg;
	reg rx_s1_reg;
	reg rx_s2_reg;

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s1_reg <= 4'h0;
			pin_s2_reg <= 4'h0;
			pin_d_reg <= 4'h0;
			jmp_s1_reg <= 4'h0;
			jmp_s2_reg <= 4'h0;
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
		end else begin
			pin_s1_reg <= PULSE_IN;
			pin_s2_reg <= pin_s1_reg;
			pin_d_reg <= pin_s2_reg;
			jmp_s1_reg <= ADDR_JUMPER;
			jmp_s2_reg <= jmp_s1_reg;
			rx_s1_reg <= SER_RX;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	// One cycle per rising edge; 10 kHz is far below the clock
	wire [3:0] pulse_rise = pin_s2_reg & ~pin_d_reg;

	// Jumpers caught once after reset release, A position reads as ten
	reg [3:0] addr_reg;
	reg addr_got_reg;
	reg [1:0] addr_wait_reg;
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			addr_reg <= 4'h0;
			addr_got_reg <= 1'b0;
			addr_wait_reg <= 2'h0;
		end else if (!addr_got_reg) begin
			// Wait until the synchroniser holds real pin levels
			addr_wait_reg <= addr_wait_reg + 2'h1;
			if (addr_wait_reg == `PCT_JMP_WAIT) begin
				addr_reg <= jmp_s2_reg;
				addr_got_reg <= 1'b1;
			end
		end
	end
	wire addr_ok = addr_got_reg & (addr_reg != 4'h0);

	// Window timebase: second, minute and hour strobes
	reg [31:0] sec_cnt_reg;
	reg [5:0] sec_in_min_reg;
	reg [5:0] min_in_hour_reg;
	reg sec_tick_reg;
	reg min_tick_reg;
	reg hour_tick_reg;
	wire sec_end = (sec_cnt_reg == SEC_LAST);
	wire min_end = sec_end & (sec_in_min_reg == `PCT_SEC_PER_MIN);
	wire hour_end = min_end & (min_in_hour_reg == `PCT_MIN_PER_HOUR);
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sec_cnt_reg <= 32'h0000_0000;
			sec_in_min_reg <= 6'h00;
			min_in_hour_reg <= 6'h00;
			sec_tick_reg <= 1'b0;
			min_tick_reg <= 1'b0;
			hour_tick_reg <= 1'b0;
		end else begin
			sec_tick_reg <= sec_end;
			min_tick_reg <= min_end;
			hour_tick_reg <= hour_end;
			sec_cnt_reg <= sec_end ? 32'h0000_0000
				: sec_cnt_reg + 32'h0000_0001;
			if (min_end)
				sec_in_min_reg <= 6'h00;
			else if (sec_end)
				sec_in_min_reg <= sec_in_min_reg + 6'h01;
			if (hour_end)
				min_in_hour_reg <= 6'h00;
			else if (min_end)
				min_in_hour_reg <= min_in_hour_reg + 6'h01;
		end
	end

	// Heartbeat toggles only after the address has been caught
	reg [31:0] hb_cnt_reg;
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			hb_cnt_reg <= 32'h0000_0000;
			ACTIVITY_LED <= 1'b0;
		end else if (addr_got_reg) begin
			if (hb_cnt_reg == HB_LAST) begin
				hb_cnt_reg <= 32'h0000_0000;
				ACTIVITY_LED <= ~ACTIVITY_LED;
			end else begin
				hb_cnt_reg <= hb_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// Software state
	reg [7:0] mode_reg;
	reg [63:0] mult_reg;
	reg [3:0] clr_reg;
	wire [79:0] total_all;
	wire [127:0] virt_all;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			// Input i feeds total i and virtual channel i + 4
			pct_chan u_chan (
				.clk(CLK),
				.rst_b(RST_B),
				.pulse(pulse_rise[i]),
				.clr(clr_reg[i]),
				.mult(mult_reg[16*i+15:16*i]),
				.mode(mode_reg[2*i+1:2*i]),
				.sec_tick(sec_tick_reg),
				.min_tick(min_tick_reg),
				.hour_tick(hour_tick_reg),
				.total_reg(total_all[20*i+19:20*i]),
				.virt_reg(virt_all[32*i+31:32*i])
			);
		end
	endgenerate

	wire ser_tx;
	wire ser_oe;
	pct_ser #(
		.BIT_CYC(BIT_CYC)
	) u_ser (
		.clk(CLK),
		.rst_b(RST_B),
		.rx(rx_s2_reg),
		.my_addr(addr_reg),
		.addr_ok(addr_ok),
		.tx_reg(ser_tx),
		.tx_oe_reg(ser_oe),
		.hit_reg()
	);
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			SER_TX <= 1'b1;
			SER_TX_OE <= 1'b0;
		end else begin
			SER_TX <= ser_tx;
			SER_TX_OE <= ser_oe;
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	reg aw_have_reg;
	reg w_have_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire [1:0] widx = aw_addr_reg[3:2];
	wire [31:0] mult_old = {16'h0000, mult_reg[16*widx+:16]};
	wire [31:0] mult_new = (mult_old & ~wmask) | (w_data_reg & wmask);
	wire [31:0] mode_new = ({24'h00_0000, mode_reg} & ~wmask)
		| (w_data_reg & wmask);
	wire do_write = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
	wire wr_mode = (aw_addr_reg == `PCT_OFF_MODE);
	wire wr_clear = (aw_addr_reg == `PCT_OFF_CLEAR);
	wire wr_mult = ((aw_addr_reg & `PCT_GRP_MASK) == `PCT_OFF_MULT)
		& (aw_addr_reg[1:0] == 2'h0);
	wire wr_ro = (aw_addr_reg == `PCT_OFF_STATUS)
		| (((aw_addr_reg & `PCT_GRP_MASK) == `PCT_OFF_TOTAL)
		& (aw_addr_reg[1:0] == 2'h0))
		| (((aw_addr_reg & `PCT_GRP_MASK) == `PCT_OFF_VIRT)
		& (aw_addr_reg[1:0] == 2'h0));

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `PCT_RESP_OKAY;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			mode_reg <= 8'h00;
			mult_reg <= {4{`PCT_MULT_RST}};
			clr_reg <= 4'h0;
		end else begin
			clr_reg <= 4'h0;
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_addr_reg <= S_AXI_AWADDR;
				aw_have_reg <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
				w_have_reg <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= `PCT_RESP_OKAY;
				if (wr_mode)
					mode_reg <= mode_new[7:0];
				else if (wr_clear)
					clr_reg <= w_data_reg[3:0] & wmask[3:0];
				else if (wr_mult)
					mult_reg[16*widx+:16] <= mult_new[15:0];
				else if (!wr_ro)
					S_AXI_BRESP <= `PCT_RESP_SLVERR;
			end
			if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// AXI4-Lite read path
	wire [1:0] ridx = S_AXI_ARADDR[3:2];
	wire rd_word = (S_AXI_ARADDR[1:0] == 2'h0);
	wire [7:0] rgrp = S_AXI_ARADDR & `PCT_GRP_MASK;
	reg [31:0] rd_val;
	reg rd_err;
	always @* begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (S_AXI_ARADDR == `PCT_OFF_STATUS)
			rd_val = {26'h000_0000, ACTIVITY_LED, addr_ok, addr_reg};
		else if (S_AXI_ARADDR == `PCT_OFF_MODE)
			rd_val = {24'h00_0000, mode_reg};
		else if (S_AXI_ARADDR == `PCT_OFF_CLEAR)
			rd_val = 32'h0000_0000;
		else if (rd_word & (rgrp == `PCT_OFF_MULT))
			rd_val = {16'h0000, mult_reg[16*ridx+:16]};
		else if (rd_word & (rgrp == `PCT_OFF_TOTAL))
			rd_val = {12'h000, total_all[20*ridx+:20]};
		else if (rd_word & (rgrp == `PCT_OFF_VIRT))
			rd_val = virt_all[32*ridx+:32];
		else
			rd_err = 1'b1;
	end

	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `PCT_RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID & S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_val;
				S_AXI_RRESP <= rd_err ? `PCT_RESP_SLVERR : `PCT_RESP_OKAY;
			end
			if (S_AXI_RVALID & S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end
endmodule
